// ### bench/host_bus_model.sv
`timescale 1ns/10ps
`include "light_prox_cfg.svh"
module host_bus_model (
  input  wire logic  i_clock,
  input  wire logic  i_sda,
  output logic       o_scl,
  output logic       o_sda_oe_n,
  output logic [7:0] o_rd_data,
  output logic       o_rd_done
);
  // six clocks a phase keeps scl high and low above four clocks
  localparam int H = 6;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
    o_rd_data = 8'h00;
    o_rd_done = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wt
  // start or repeated start, data falls while clock high
  task automatic start_c();
    o_sda_oe_n = 1'b1;
    wt(H);
    o_scl = 1'b1;
    wt(H);
    o_sda_oe_n = 1'b0;
    wt(H);
    o_scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    o_sda_oe_n = 1'b0;
    wt(H);
    o_scl = 1'b1;
    wt(H);
    o_sda_oe_n = 1'b1;
    wt(H);
  endtask : stop_c
  // msb first, ninth bit is the acknowledge slot
  task automatic byte_x(input logic [7:0] tx, input logic ak_i,
                        output logic [7:0] rx, output logic ak);
    logic [8:0] v;
    v = {tx, ak_i};
    for (int i = 8; i >= 0; i--) begin
      o_sda_oe_n = v[i];
      wt(H);
      o_scl = 1'b1;
      wt(H);
      v[i] = i_sda;
      o_scl = 1'b0;
      wt(H);
    end
    rx = v[8:1];
    ak = v[0];
  endtask : byte_x
  // address, register byte, one data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
                           input logic [7:0] wd, output logic ak);
    logic [7:0] rx;
    logic       a2;
    start_c();
    byte_x({dev, 1'b0}, 1'b1, rx, ak);
    if (ak === 1'b0) begin
      byte_x(ra, 1'b1, rx, a2);
      byte_x(wd, 1'b1, rx, a2);
    end
    stop_c();
  endtask : write_reg
  // register byte, repeated start, one byte ended by nack
  task automatic read_reg(input logic [7:0] ra);
    logic [7:0] rx;
    logic       ak;
    start_c();
    byte_x({`LP_SLAVE_ADDR, 1'b0}, 1'b1, rx, ak);
    byte_x(ra, 1'b1, rx, ak);
    start_c();
    byte_x({`LP_SLAVE_ADDR, 1'b1}, 1'b1, rx, ak);
    byte_x(8'hff, 1'b1, rx, ak);
    stop_c();
    o_rd_data = rx;
    o_rd_done = 1'b1;
    wt(1);
    o_rd_done = 1'b0;
  endtask : read_reg
endmodule : host_bus_model

// ### bench/tb.sv
`timescale 1ns/10ps
`include "light_prox_cfg.svh"
module tb;
  import light_prox_pkg::*;
  logic            i_clock, i_rst, shot, scl, h_oe_n, s_out, s_oe_n;
  logic            req, ph, busy, valid, rd_done, extra, ak;
  adc_sample_t     adc;
  ambient_params_t params;
  logic [4:0]      steps;
  logic [15:0]     result, a_val, o_val;
  logic [7:0]      rd_data;
  logic [5:0]      c;
  logic [5:0]      codes [4];
  logic [2:0]      rq_sh, ph_sh;
  logic [15:0]     rq [$];
  logic [15:0]     mq [$];
  int              fails, checked, seed, n;
  wire             sda = (s_oe_n | s_out) & h_oe_n;
  light_prox_param_regs uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(s_out), .o_sda_oe_n(s_oe_n), .i_ambient_single_shot(shot),
    .i_adc(adc), .o_emitter_steps(steps), .o_params(params),
    .o_conv_req(req), .o_offset_phase(ph), .o_ambient_busy(busy),
    .o_ambient_result(result), .o_ambient_valid(valid));
  host_bus_model host (
    .i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(h_oe_n),
    .o_rd_data(rd_data), .o_rd_done(rd_done));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // front end answers four cycles after each request
  always @(posedge i_clock) begin
    if (i_rst) begin
      rq_sh <= 3'h0;
      ph_sh <= 3'h0;
      adc <= '0;
    end else begin
      rq_sh <= {rq_sh[1:0], req};
      ph_sh <= {ph_sh[1:0], ph};
      adc.valid <= rq_sh[2];
      adc.data <= rq_sh[2] ? (ph_sh[2] ? o_val : a_val) : ~adc.data;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge i_clock) begin
    if (rd_done === 1'b1)
      check(rd_data, rq.pop_front());
    if (valid === 1'b1) begin
      if (mq.size() > 0)
        check(result, mq.pop_front());
      else if (!extra)
        check(16'h0001, 16'h0000);
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    host.write_reg(`LP_SLAVE_ADDR, ra, wd, ak);
    check({15'h0, ak}, 16'h0000);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    rq.push_back({8'h00, exp});
    host.read_reg(ra);
  endtask : rd
  task automatic pulse();
    shot = 1'b1;
    tick(1);
    shot = 1'b0;
  endtask : pulse
  task automatic drain(input int lim);
    n = 0;
    while (mq.size() > 0 && n < lim) begin
      @(posedge i_clock);
      n++;
    end
    if (mq.size() > 0) begin
      fails++;
      end_of_test();
    end
    tick(20);
  endtask : drain
  task automatic meas(input logic [2:0] avg, input logic offs);
    wr(`LP_ADDR_PARAMS, {4'h0, offs, avg});
    check({11'h0, params}, {11'h0, 1'b0, offs, avg});
    a_val = 16'($random(seed));
    o_val = 16'($random(seed));
    if (offs)
      mq.push_back((o_val > a_val) ? 16'h0000 : a_val - o_val);
    else
      mq.push_back(a_val);
    pulse();
    tick(4);
    pulse(); // refused while busy
    drain(2000);
  endtask : meas
  initial begin
    seed = 25;
    fails = 0;
    checked = 0;
    extra = 1'b0;
    shot = 1'b0;
    a_val = 16'h0000;
    o_val = 16'h0000;
    codes = '{6'h00, 6'h14, 6'h15, 6'h3f};
    i_rst = 1'b1;
    tick(8);
    i_rst = 1'b0;
    check({11'h0, steps}, 16'h0002);
    check({11'h0, params}, 16'h000d);
    rd(`LP_ADDR_ID, `LP_ID_VALUE);
    rd(`LP_ADDR_EMIT, {`LP_CAL_REV, 6'h02});
    rd(`LP_ADDR_PARAMS, 8'h0d);
    $display("reset values done");
    wr(`LP_ADDR_ID, 8'ha5);
    wr(`LP_ADDR_UNUSED, 8'hff);
    wr(8'h90, 8'hff);
    rd(`LP_ADDR_ID, `LP_ID_VALUE);
    rd(8'h90, 8'h00);
    rd(`LP_ADDR_UNUSED, 8'h00);
    check({11'h0, steps}, 16'h0002);
    check({11'h0, params}, 16'h000d);
    host.write_reg(7'h14, `LP_ADDR_EMIT, 8'h09, ak);
    check({15'h0, ak}, 16'h0001);
    check({11'h0, steps}, 16'h0002);
    $display("read-only and address done");
    for (int i = 0; i < 7; i++) begin
      c = (i < 4) ? codes[i] : 6'($random(seed));
      wr(`LP_ADDR_EMIT, {2'h2, c});
      check({11'h0, steps}, {11'h0, (c > 6'd20) ? 5'd20 : c[4:0]});
      rd(`LP_ADDR_EMIT, {`LP_CAL_REV, c});
    end
    $display("emitter current done");
    wr(`LP_ADDR_PARAMS, 8'h7f);
    rd(`LP_ADDR_PARAMS, 8'h0f);
    for (int i = 0; i < 8; i++)
      meas(3'(i), i[0]);
    $display("single measurements done");
    a_val = 16'($random(seed));
    repeat (3) mq.push_back(a_val);
    wr(`LP_ADDR_PARAMS, 8'h81);
    check({11'h0, params}, 16'h0011);
    extra = 1'b1;
    drain(3000);
    wr(`LP_ADDR_PARAMS, 8'h01);
    tick(100);
    mq.delete();
    extra = 1'b0;
    tick(100);
    $display("continuous mode done");
    end_of_test();
  end
endmodule : tb

// ### hdl/ambient_averager.sv
`timescale 1ns/10ps
module ambient_averager
  import light_prox_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_rst,
  input  wire logic            i_start,
  input  wire ambient_params_t i_params,
  input  wire adc_sample_t     i_adc,
  output logic                 o_conv_req,
  output logic                 o_offset_phase,
  output logic                 o_busy,
  output logic [15:0]          o_result,
  output logic                 o_result_valid
);

  avg_state_t  state_q,  state_d;
  logic [2:0]  exp_q,    exp_d;
  logic [7:0]  cnt_q,    cnt_d;
  logic [15:0] offs_q,   offs_d;
  logic [22:0] acc_q,    acc_d;
  logic [15:0] res_q,    res_d;
  logic        rv_q,     rv_d;
  logic        req_q,    req_d;
  logic        ph_q,     ph_d;
  logic        busy_q,   busy_d;
  logic [15:0] corr;
  logic [22:0] sum;

  always_comb begin
    state_d = state_q;
    exp_d   = exp_q;
    cnt_d   = cnt_q;
    offs_d  = offs_q;
    acc_d   = acc_q;
    res_d   = res_q;
    rv_d    = 1'b0;
    req_d   = 1'b0;
    // offset removed from each conversion, floored at zero
    corr = (i_adc.data > offs_q) ? i_adc.data - offs_q : 16'h0000; // [RULE11]
    sum  = acc_q + {7'h00, corr};
    case (state_q)
      AV_IDLE: begin
        if (i_start) begin
          exp_d  = i_params.avg_exp;
          cnt_d  = 8'h00;
          acc_d  = 23'h000000;
          offs_d = 16'h0000;
          req_d  = 1'b1;
          state_d = i_params.offset_en ? AV_OFFSET : AV_CONV; // [RULE11]
        end
      end
      AV_OFFSET: begin
        if (i_adc.valid) begin
          offs_d  = i_adc.data; // [RULE11]
          req_d   = 1'b1;
          state_d = AV_CONV;
        end
      end
      AV_CONV: begin
        if (i_adc.valid) begin
          acc_d = sum;
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == (8'h01 << exp_q) - 8'h01) begin // [RULE12]
            // only the averaged value reaches the result
            res_d   = 16'(sum >> exp_q); // [RULE12] [RULE14]
            rv_d    = 1'b1;
            state_d = AV_IDLE;
          end else begin
            req_d = 1'b1;
          end
        end
      end
      default: state_d = AV_IDLE;
    endcase
    // phase and busy registered so the outputs come from flops
    ph_d   = (state_d == AV_OFFSET);
    busy_d = (state_d != AV_IDLE);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= AV_IDLE;
      exp_q   <= 3'h0;
      cnt_q   <= 8'h00;
      offs_q  <= 16'h0000;
      acc_q   <= 23'h000000;
      res_q   <= 16'h0000;
      rv_q    <= 1'b0;
      req_q   <= 1'b0;
      ph_q    <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      exp_q   <= exp_d;
      cnt_q   <= cnt_d;
      offs_q  <= offs_d;
      acc_q   <= acc_d;
      res_q   <= res_d;
      rv_q    <= rv_d;
      req_q   <= req_d;
      ph_q    <= ph_d;
      busy_q  <= busy_d;
    end
  end

  assign o_conv_req     = req_q;
  assign o_offset_phase = ph_q;
  assign o_busy         = busy_q;
  assign o_result       = res_q;
  assign o_result_valid = rv_q;

endmodule : ambient_averager

// ### hdl/light_prox_param_regs.sv
`timescale 1ns/10ps
`include "light_prox_cfg.svh"
// How it works
// [RULE1] id register at 81h, product and revision
// [RULE2] id fields ignore host writes
// [RULE3] slot 82h has no function
// [RULE4] emitter code read-write, drive is code times 10mA
// [RULE5] host programs emitter code 0 to 20
// [RULE6] emitter code resets to two
// [RULE7] codes above twenty clamp to 200mA
// [RULE8] upper bits report calibration revision read-only
// [RULE9] calibration bits 7:6, emitter code bits 5:0
// [RULE10] bit 7 continuous conversion, resets to zero
// [RULE11] bit 3 offset measured and subtracted, default on
// [RULE12] bits 2:0 give 2^n conversions, averaged
// [RULE13] averaging resets to 32 conversions
// [RULE14] single shot stores only the averaged result
// [RULE15] serial bus address 13h, register byte first
module light_prox_param_regs
  import light_prox_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe_n,
  input  wire logic        i_ambient_single_shot,
  input  wire adc_sample_t i_adc,
  output logic [4:0]       o_emitter_steps,
  output ambient_params_t  o_params,
  output logic             o_conv_req,
  output logic             o_offset_phase,
  output logic             o_ambient_busy,
  output logic [15:0]      o_ambient_result,
  output logic             o_ambient_valid
);

  // pin synchronisers
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q, sda_prev_q;
  logic       scl, sda, scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl        = scl_sync_q[1];
  assign sda        = sda_sync_q[1];
  assign scl_rise   = scl & ~scl_prev_q;
  assign scl_fall   = ~scl & scl_prev_q;
  assign start_cond = scl & scl_prev_q & ~sda & sda_prev_q;
  assign stop_cond  = scl & scl_prev_q & sda & ~sda_prev_q;

  // parameter registers
  logic [5:0]      emit_q, emit_d;
  ambient_params_t par_q,  par_d;
  logic [4:0]      steps_q, steps_d;

  function automatic logic [7:0] reg_read(
    input logic [7:0]      addr,
    input logic [5:0]      emit,
    input ambient_params_t par
  );
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `LP_ADDR_ID:     v = `LP_ID_VALUE; // [RULE1]
      `LP_ADDR_UNUSED: v = 8'h00; // [RULE3]
      `LP_ADDR_EMIT:   v = {`LP_CAL_REV, emit}; // [RULE8] [RULE9]
      `LP_ADDR_PARAMS: v = {par.cont, 3'h0, par.offset_en, par.avg_exp};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // bus engine
  bus_state_t st_q,   st_d;
  logic [7:0] sh_q,   sh_d;
  logic [3:0] cnt_q,  cnt_d;
  logic [7:0] ptr_q,  ptr_d;
  logic       hp_q,   hp_d;
  logic       rw_q,   rw_d;
  logic       nack_q, nack_d;
  logic       low_q,  low_d;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;

  assign rd_byte = reg_read(ptr_q, emit_q, par_q);

  always_comb begin
    st_d    = st_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    ptr_d   = ptr_q;
    hp_d    = hp_q;
    rw_d    = rw_q;
    nack_d  = nack_q;
    low_d   = low_q;
    wr_en   = 1'b0;
    wr_data = sh_q;
    if (stop_cond) begin
      st_d  = ST_IDLE;
      low_d = 1'b0;
    end else if (start_cond) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      low_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: low_d = 1'b0;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == `LP_SLAVE_ADDR) begin // [RULE15]
                rw_d  = sh_q[0];
                low_d = 1'b1;
                st_d  = ST_ACK_ADDR;
              end else begin
                st_d = ST_IDLE;
              end
            end else begin
              low_d = 1'b1;
              st_d  = ST_ACK_RX;
              if (!hp_q) begin
                ptr_d = sh_q; // [RULE15]
                hp_d  = 1'b1;
              end else begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_q) begin
              sh_d  = rd_byte;
              low_d = ~rd_byte[7];
              st_d  = ST_TX;
            end else begin
              hp_d  = 1'b0;
              low_d = 1'b0;
              st_d  = ST_RX;
            end
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            low_d = 1'b0;
            st_d  = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              cnt_d = 4'h0;
              low_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d  = ST_ACK_TX;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
              low_d = ~sh_q[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            nack_d = sda;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = ST_IDLE;
            end else begin
              sh_d  = rd_byte;
              low_d = ~rd_byte[7];
              st_d  = ST_TX;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q   <= ST_IDLE;
      sh_q   <= 8'h00;
      cnt_q  <= 4'h0;
      ptr_q  <= 8'h00;
      hp_q   <= 1'b0;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
      low_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      ptr_q  <= ptr_d;
      hp_q   <= hp_d;
      rw_q   <= rw_d;
      nack_q <= nack_d;
      low_q  <= low_d;
    end
  end

  // register writes, id and unused slot take none
  always_comb begin
    emit_d = emit_q;
    par_d  = par_q;
    if (wr_en) begin
      case (ptr_q)
        `LP_ADDR_EMIT: emit_d = wr_data[`LP_EMIT_MSB:`LP_EMIT_LSB]; // [RULE4]
        `LP_ADDR_PARAMS: begin
          par_d.cont      = wr_data[`LP_CONT_BIT]; // [RULE10]
          par_d.offset_en = wr_data[`LP_OFFS_BIT]; // [RULE11]
          par_d.avg_exp   = wr_data[`LP_AVG_MSB:`LP_AVG_LSB]; // [RULE12]
        end
        default: emit_d = emit_q; // [RULE2] [RULE3]
      endcase
    end
    // drive steps of 10mA, clamped at twenty
    steps_d = (emit_q > `LP_EMIT_MAX) ? 5'(`LP_EMIT_MAX) // [RULE7]
                                      : emit_q[4:0]; // [RULE4] [RULE5]
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      emit_q        <= `LP_EMIT_RESET; // [RULE6]
      par_q.cont    <= `LP_CONT_RESET; // [RULE10]
      par_q.offset_en <= `LP_OFFS_RESET; // [RULE11]
      par_q.avg_exp <= `LP_AVG_RESET; // [RULE13]
      steps_q       <= 5'h02;
    end else begin
      emit_q  <= emit_d;
      par_q   <= par_d;
      steps_q <= steps_d;
    end
  end

  // measurement launch, single shot or continuous
  logic amb_busy, go_q, go_d;

  always_comb begin
    go_d = (i_ambient_single_shot | par_q.cont) & ~amb_busy & ~go_q; // [RULE10]
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_d;
    end
  end

  ambient_averager u_avg (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_start        (go_q),
    .i_params       (par_q),
    .i_adc          (i_adc),
    .o_conv_req     (o_conv_req),
    .o_offset_phase (o_offset_phase),
    .o_busy         (amb_busy),
    .o_result       (o_ambient_result),
    .o_result_valid (o_ambient_valid) // [RULE14]
  );

  assign o_sda_out       = 1'b0;
  assign o_sda_oe_n      = ~low_q;
  assign o_emitter_steps = steps_q;
  assign o_params        = par_q;
  assign o_ambient_busy  = amb_busy;

  property p_id_fixed;
    @(posedge i_clock) disable iff (i_rst)
      (wr_en && ptr_q == `LP_ADDR_ID) |=>
        $stable(emit_q) && $stable(par_q) &&
        reg_read(`LP_ADDR_ID, emit_q, par_q) == `LP_ID_VALUE;
  endproperty
  a_id_fixed: assert property (p_id_fixed) // [RULE1] [RULE2]
    else $error("id register changed by a write");

  property p_unused_zero;
    @(posedge i_clock) disable iff (i_rst)
      (wr_en && ptr_q == `LP_ADDR_UNUSED) |=>
        $stable(emit_q) && $stable(par_q) &&
        reg_read(`LP_ADDR_UNUSED, emit_q, par_q) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [RULE3]
    else $error("unused slot reads nonzero");

  property p_emit_drive;
    @(posedge i_clock) disable iff (i_rst)
      (wr_en && ptr_q == `LP_ADDR_EMIT && wr_data[5:0] <= 6'h14) |=>
        ##1 o_emitter_steps == $past(wr_data[4:0], 2);
  endproperty
  a_emit_drive: assert property (p_emit_drive) // [RULE4]
    else $error("emitter drive does not follow code");

  property p_emit_clamp;
    @(posedge i_clock) disable iff (i_rst)
      (emit_q > `LP_EMIT_MAX) |=> o_emitter_steps == 5'h14;
  endproperty
  a_emit_clamp: assert property (p_emit_clamp) // [RULE7]
    else $error("emitter drive not clamped");

  property p_reset_vals;
    @(posedge i_clock)
      $past(i_rst) |-> (emit_q == 6'h02 && !par_q.cont &&
                        par_q.offset_en && par_q.avg_exp == 3'h5);
  endproperty
  a_reset_vals: assert property (p_reset_vals) // [RULE6] [RULE10] [RULE13]
    else $error("parameter reset values wrong");

  property p_cal_field;
    @(posedge i_clock) disable iff (i_rst)
      (wr_en && ptr_q == `LP_ADDR_EMIT) |=>
        emit_q == $past(wr_data[5:0]) &&
        reg_read(`LP_ADDR_EMIT, emit_q, par_q) == {`LP_CAL_REV, emit_q};
  endproperty
  a_cal_field: assert property (p_cal_field) // [RULE8] [RULE9]
    else $error("calibration field altered");

  property p_cont_launch;
    @(posedge i_clock) disable iff (i_rst)
      (par_q.cont && !amb_busy && !go_q) |=> go_q;
  endproperty
  a_cont_launch: assert property (p_cont_launch) // [RULE10]
    else $error("continuous mode did not launch");

  property p_addr_ack;
    @(posedge i_clock) disable iff (i_rst)
      (st_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && !stop_cond &&
       !start_cond && sh_q[7:1] == `LP_SLAVE_ADDR) |=> !o_sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // [RULE15]
    else $error("own address not acknowledged");

  property p_offset_first;
    @(posedge i_clock) disable iff (i_rst)
      (go_q && par_q.offset_en) |=> o_offset_phase;
  endproperty
  a_offset_first: assert property (p_offset_first) // [RULE11]
    else $error("no offset phase before measurement");

endmodule : light_prox_param_regs

// ### pkg/light_prox_cfg.svh
`ifndef LIGHT_PROX_CFG_SVH
`define LIGHT_PROX_CFG_SVH

// register addresses
`define LP_ADDR_ID        8'h81
`define LP_ADDR_UNUSED    8'h82
`define LP_ADDR_EMIT      8'h83
`define LP_ADDR_PARAMS    8'h84

// bus address, 7 bits
`define LP_SLAVE_ADDR     7'h13

// id and calibration revision values, arbitrary
`define LP_ID_VALUE       8'h5a
`define LP_CAL_REV        2'h1

// emitter register fields
`define LP_CAL_MSB        7
`define LP_CAL_LSB        6
`define LP_EMIT_MSB       5
`define LP_EMIT_LSB       0
`define LP_EMIT_RESET     6'h02
`define LP_EMIT_MAX       6'h14

// parameter register fields
`define LP_CONT_BIT       7
`define LP_OFFS_BIT       3
`define LP_AVG_MSB        2
`define LP_AVG_LSB        0
`define LP_CONT_RESET     1'h0
`define LP_OFFS_RESET     1'h1
`define LP_AVG_RESET      3'h5

`endif

// ### pkg/light_prox_pkg.sv
package light_prox_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_RX       = 3'b011,
    ST_ACK_RX   = 3'b100,
    ST_TX       = 3'b101,
    ST_ACK_TX   = 3'b110
  } bus_state_t;

  typedef enum logic [1:0] {
    AV_IDLE   = 2'b00,
    AV_OFFSET = 2'b01,
    AV_CONV   = 2'b10
  } avg_state_t;

  typedef struct packed {
    logic       cont;
    logic       offset_en;
    logic [2:0] avg_exp;
  } ambient_params_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } adc_sample_t;

endpackage : light_prox_pkg
